// ---- rtl/irq_map_defs.svh ----
// Constants for the interrupt position map and the external edge lines.
`ifndef IRQ_MAP_DEFS_SVH
`define IRQ_MAP_DEFS_SVH
`define SLOT_CNT     8
`define LINE_CNT     18
`define ALARM_LINE   17
`define SLOT_P24     0
`define SLOT_P25     1
`define SLOT_P26     2
`define SLOT_P27     3
`define SLOT_P41     4
`define SLOT_P54     5
`define SLOT_P59     6
`define SLOT_P60     7
`define POS_P24      6'h18
`define POS_P25      6'h19
`define POS_P26      6'h1A
`define POS_P27      6'h1B
`define POS_P41      6'h29
`define POS_P54      6'h36
`define POS_P59      6'h3B
`define POS_P60      6'h3C
`define POS_RSV_LO   6'h13
`define POS_RSV_HI   6'h16
`define POS_RSV_46   6'h2E
`define POS_RSV_47   6'h2F
`define POS_RSV_49   6'h31
`define VEC_BASE     32'h0000_0040
`define VEC_P24      32'h0000_00A0
`define VEC_P25      32'h0000_00A4
`define VEC_P26      32'h0000_00A8
`define VEC_P27      32'h0000_00AC
`define VEC_P41      32'h0000_00E4
`define VEC_P54      32'h0000_0118
`define VEC_P59      32'h0000_012C
`define VEC_P60      32'h0000_0130
`define PRIO_RESET   4'h0
`endif

// ---- rtl/irq_map_pkg.sv ----
// Types shared by the interrupt map and the edge line front end.
package irq_map_pkg;
    typedef logic [7:0]      slot_vec_t;
    typedef logic [17:0]     line_vec_t;
    typedef logic [3:0]      prio_t;
    typedef logic [5:0]      pos_t;
    typedef logic [7:0][3:0] prio_arr_t;

    typedef struct packed {
        line_vec_t sync1;
        line_vec_t sync2;
        line_vec_t sync3;
        line_vec_t level;
        line_vec_t pend;
        line_vec_t irq;
        line_vec_t evt;
    } edge_state_t;

    typedef struct packed {
        slot_vec_t   irq;
        logic        best_valid;
        pos_t        best_pos;
        prio_t       best_prio;
        logic [31:0] best_vec;
        logic        q_valid;
        logic [31:0] q_addr;
    } map_state_t;
endpackage : irq_map_pkg

// ---- rtl/edge_line_if.sv ----
// Configuration and status carrier between the map and the edge line front end.
`timescale 1ns/100ps
interface edge_line_if;
    irq_map_pkg::line_vec_t rise_en;
    irq_map_pkg::line_vec_t fall_en;
    irq_map_pkg::line_vec_t irq_en;
    irq_map_pkg::line_vec_t evt_en;
    irq_map_pkg::line_vec_t pend_type;
    irq_map_pkg::line_vec_t sw_trig;
    irq_map_pkg::line_vec_t pend_clr;
    irq_map_pkg::line_vec_t pins;
    irq_map_pkg::line_vec_t pend;
    irq_map_pkg::line_vec_t irq;
    irq_map_pkg::line_vec_t evt;

    modport ctrl  (output rise_en, fall_en, irq_en, evt_en, pend_type, sw_trig, pend_clr,
                   pins, input pend, irq, evt);
    modport lines (input rise_en, fall_en, irq_en, evt_en, pend_type, sw_trig, pend_clr,
                   pins, output pend, irq, evt);
endinterface : edge_line_if

// ---- rtl/external_edge_line_ctrl.sv ----
// Edge detectors, masks and pending bits for the external edge lines.
`timescale 1ns/100ps
`include "irq_map_defs.svh"
module external_edge_line_ctrl (
    // Clock and reset.
    input  wire logic  core_clk_i,
    input  wire logic  rst_n_i,
    // Line configuration and status.
    edge_line_if.lines el
);
    irq_map_pkg::edge_state_t cur;
    irq_map_pkg::edge_state_t next_st;
    irq_map_pkg::line_vec_t   agree;
    irq_map_pkg::line_vec_t   rise;
    irq_map_pkg::line_vec_t   fall;
    irq_map_pkg::line_vec_t   trig;

    // A pin change counts once the second and third stages agree.
    // short pulses caught at core rate
    assign agree = ~(cur.sync2 ^ cur.sync3);
    assign rise  = agree & cur.sync3 & ~cur.level;
    assign fall  = agree & ~cur.sync3 & cur.level;
    // Selected edge or software request.
    // per-line edge choice
    assign trig  = (rise & el.rise_en) | (fall & el.fall_en) | el.sw_trig;

    // Next state; pending set wins over a clear in the same cycle.
    always_comb
    begin
        next_st       = cur;
        next_st.sync1 = el.pins;
        next_st.sync2 = cur.sync1;
        next_st.sync3 = cur.sync2;
        next_st.level = (cur.level & ~agree) | (cur.sync3 & agree);
        next_st.pend  = (cur.pend & ~el.pend_clr) | (trig & el.irq_en);
        next_st.irq   = (el.pend_type & next_st.pend) | (~el.pend_type & trig & el.irq_en);
        next_st.evt   = trig & el.evt_en;
    end

    // State register.
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_st;
        end
    end

    assign el.pend = cur.pend;
    assign el.irq  = cur.irq;
    assign el.evt  = cur.evt;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence narrow_pulse;
        (!el.pins[6] [*3] ##1 el.pins[6] [*2] ##1 !el.pins[6]);
    endsequence
    sequence line6_armed;
        (el.rise_en[6] && el.irq_en[6] && !el.pend_clr[6]);
    endsequence

    narrow_pulse_a: assert property (
        (narrow_pulse and line6_armed [*6]) ##1 line6_armed |=> el.pend[6])
        else $error("Two cycle pin pulse missed.");
    edge_pend_a: assert property (
        (rise & el.rise_en & el.irq_en) != '0
        |=> (el.pend & $past(rise & el.rise_en & el.irq_en))
            == $past(rise & el.rise_en & el.irq_en))
        else $error("Rising edge did not set pending.");
    evt_mask_a: assert property (
        1'b1 |=> (el.evt & ~$past(el.evt_en)) == '0)
        else $error("Masked line raised an event.");
    sw_req_a: assert property (
        (el.sw_trig & el.evt_en) != '0
        |=> (el.evt & $past(el.sw_trig & el.evt_en)) == $past(el.sw_trig & el.evt_en))
        else $error("Software request gave no event.");
    pulse_type_a: assert property (
        1'b1 |=> (el.irq & ~$past(el.pend_type) & ~$past(trig & el.irq_en)) == '0)
        else $error("Pulse line request without trigger.");
    fall_edge_a: assert property (
        (fall & el.fall_en & el.evt_en) != '0
        |=> (el.evt & $past(fall & el.fall_en & el.evt_en)) != '0)
        else $error("Falling edge gave no event.");
endmodule : external_edge_line_ctrl

// ---- rtl/irq_vector_map_and_edge_lines.sv ----
// Upper interrupt position map with vector selection and external edge lines.
// Function
// - Timer break and timer15 share position 24.
// - Timer update and timer16 share position 25.
// - Trigger, commutation, timer17 share position 26.
// - Capture compare alone on position 27.
// - Both alarms via edge line, position 41.
// - Timer6 or DAC underrun on position 54.
// - DMA2 channels 4 and 5 on position 59.
// - On high density parts the remap bit moves channel 5 to 60.
// - Eighteen edge detectors give interrupts or events.
// - Per line pulse/pending type and edge choice.
// - Independent mask per line.
// - Pending bit set by triggering edge.
// - Software request on any line.
// - Capture pin pulses of two core clock cycles or longer.
// - Four bit settable priority per position.
`timescale 1ns/100ps
`include "irq_map_defs.svh"
module irq_vector_map_and_edge_lines (
    // Clock and reset.
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_n_i,
    // Peripheral request sources.
    input  wire logic                      adv_timer_break_i,
    input  wire logic                      timer15_i,
    input  wire logic                      adv_timer_update_i,
    input  wire logic                      timer16_i,
    input  wire logic                      adv_timer_trigger_i,
    input  wire logic                      adv_timer_commut_i,
    input  wire logic                      timer17_i,
    input  wire logic                      adv_timer_capture_compare_i,
    input  wire logic                      alarm_a_i,
    input  wire logic                      alarm_b_i,
    input  wire logic                      basic_timer6_i,
    input  wire logic                      dac_underrun_i,
    input  wire logic                      dma_ctrl2_ch4_i,
    input  wire logic                      dma_ctrl2_ch5_i,
    // Variant and remap control.
    input  wire logic                      high_density_i,
    input  wire logic                      misc_request_remap_bit_i,
    // Settable priorities, one per mapped slot.
    input  wire irq_map_pkg::prio_arr_t    slot_prio_i,
    // Vector address query.
    input  wire irq_map_pkg::pos_t         query_pos_i,
    // External edge line pins and configuration.
    input  wire irq_map_pkg::line_vec_t    ext_lines_i,
    input  wire irq_map_pkg::line_vec_t    rise_en_i,
    input  wire irq_map_pkg::line_vec_t    fall_en_i,
    input  wire irq_map_pkg::line_vec_t    irq_en_i,
    input  wire irq_map_pkg::line_vec_t    evt_en_i,
    input  wire irq_map_pkg::line_vec_t    pend_type_i,
    input  wire irq_map_pkg::line_vec_t    sw_trig_i,
    input  wire irq_map_pkg::line_vec_t    pend_clr_i,
    // Mapped position requests and selected vector.
    output logic [7:0]                     slot_irq_o,
    output logic                           best_valid_o,
    output irq_map_pkg::pos_t              best_pos_o,
    output irq_map_pkg::prio_t             best_prio_o,
    output logic [31:0]                    best_vec_o,
    // Query answer.
    output logic                           query_valid_o,
    output logic [31:0]                    query_addr_o,
    // Edge line status and requests.
    output irq_map_pkg::line_vec_t         line_pend_o,
    output irq_map_pkg::line_vec_t         line_irq_o,
    output irq_map_pkg::line_vec_t         line_evt_o
);
    localparam irq_map_pkg::pos_t SLOT_POS [`SLOT_CNT] = '{`POS_P24, `POS_P25, `POS_P26,
        `POS_P27, `POS_P41, `POS_P54, `POS_P59, `POS_P60};

    irq_map_pkg::map_state_t cur;
    irq_map_pkg::map_state_t next_st;
    irq_map_pkg::slot_vec_t  src;
    logic                    ch5_separate;
    irq_map_pkg::line_vec_t  pins;

    edge_line_if el ();

    // The alarm pair enters through the top edge line.
    // alarms through edge line
    assign pins         = {alarm_a_i | alarm_b_i, ext_lines_i[`ALARM_LINE-1:0]};
    assign el.pins      = pins;
    assign el.rise_en   = rise_en_i;
    assign el.fall_en   = fall_en_i;
    assign el.irq_en    = irq_en_i;
    assign el.evt_en    = evt_en_i;
    assign el.pend_type = pend_type_i;
    assign el.sw_trig   = sw_trig_i;
    assign el.pend_clr  = pend_clr_i;

    external_edge_line_ctrl u_edge (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .el         (el)
    );

    // Channel 5 leaves the shared slot only on remapped large parts.
    // remap selects position 60
    assign ch5_separate = high_density_i & misc_request_remap_bit_i;

    // Source merging onto positions; each slot is an OR of its sources.
    always_comb
    begin
        src = '0;
        src[`SLOT_P24] = adv_timer_break_i | timer15_i;
        src[`SLOT_P25] = adv_timer_update_i | timer16_i;
        src[`SLOT_P26] = adv_timer_trigger_i | adv_timer_commut_i | timer17_i;
        src[`SLOT_P27] = adv_timer_capture_compare_i;
        src[`SLOT_P41] = el.irq[`ALARM_LINE];
        src[`SLOT_P54] = basic_timer6_i | dac_underrun_i;
        src[`SLOT_P59] = dma_ctrl2_ch4_i | (dma_ctrl2_ch5_i & ~ch5_separate);
        src[`SLOT_P60] = dma_ctrl2_ch5_i & ch5_separate;
    end

    // Next state: registered requests, priority pick and query answer.
    always_comb
    begin
        next_st     = cur;
        next_st.irq = src;
        next_st.best_valid = 1'b0;
        next_st.best_pos   = '0;
        next_st.best_prio  = `PRIO_RESET;
        for (int i = 0; i < `SLOT_CNT; i++)
        begin
            if (cur.irq[i] && (!next_st.best_valid || slot_prio_i[i] < next_st.best_prio))
            begin
                next_st.best_valid = 1'b1;
                next_st.best_pos   = SLOT_POS[i];
                next_st.best_prio  = slot_prio_i[i];
            end
        end
        next_st.best_vec = `VEC_BASE + {24'h00_0000, next_st.best_pos, 2'b00};
        next_st.q_addr   = `VEC_BASE + {24'h00_0000, query_pos_i, 2'b00};
        next_st.q_valid  = !((query_pos_i >= `POS_RSV_LO && query_pos_i <= `POS_RSV_HI)
                             || query_pos_i == `POS_RSV_46 || query_pos_i == `POS_RSV_47
                             || query_pos_i == `POS_RSV_49 || query_pos_i > `POS_P60
                             || (query_pos_i == `POS_P60 && !high_density_i));
    end

    // State register.
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_st;
        end
    end

    // Outputs come straight from the state flops.
    assign slot_irq_o    = cur.irq;
    assign best_valid_o  = cur.best_valid;
    assign best_pos_o    = cur.best_pos;
    assign best_prio_o   = cur.best_prio;
    assign best_vec_o    = cur.best_vec;
    assign query_valid_o = cur.q_valid;
    assign query_addr_o  = cur.q_addr;
    assign line_pend_o   = el.pend;
    assign line_irq_o    = el.irq;
    assign line_evt_o    = el.evt;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence ch5_only;
        dma_ctrl2_ch5_i && !dma_ctrl2_ch4_i;
    endsequence

    merge_p24_a: assert property (
        (adv_timer_break_i || timer15_i) |=> slot_irq_o[`SLOT_P24])
        else $error("Position 24 not raised.");
    merge_p25_a: assert property (
        (adv_timer_update_i || timer16_i) |=> slot_irq_o[`SLOT_P25])
        else $error("Position 25 not raised.");
    merge_p26_a: assert property (
        (adv_timer_trigger_i || adv_timer_commut_i || timer17_i) |=> slot_irq_o[`SLOT_P26])
        else $error("Position 26 not raised.");
    cc_p27_a: assert property (
        slot_irq_o[`SLOT_P27] == $past(adv_timer_capture_compare_i))
        else $error("Position 27 does not follow its source.");
    alarm_p41_a: assert property (
        el.irq[`ALARM_LINE] |=> slot_irq_o[`SLOT_P41])
        else $error("Alarm line did not raise position 41.");
    dac_p54_a: assert property (
        (!basic_timer6_i && !dac_underrun_i) |=> !slot_irq_o[`SLOT_P54])
        else $error("Position 54 raised with no source.");
    dma_shared_a: assert property (
        (ch5_only and !ch5_separate) |=> slot_irq_o[`SLOT_P59] && !slot_irq_o[`SLOT_P60])
        else $error("Channel 5 not merged at 59.");
    dma_remap_a: assert property (
        (ch5_only and ch5_separate) |=> !slot_irq_o[`SLOT_P59] && slot_irq_o[`SLOT_P60])
        else $error("Channel 5 not moved to 60.");
    shared_hold_a: assert property (
        timer15_i [*2] |-> slot_irq_o[`SLOT_P24] ##1 slot_irq_o[`SLOT_P24])
        else $error("Shared position dropped while source active.");
    prio_pick_a: assert property (
        (slot_irq_o[`SLOT_P24] && slot_irq_o[`SLOT_P25]
        && slot_prio_i[`SLOT_P25] < slot_prio_i[`SLOT_P24]) |=> best_pos_o != `POS_P24)
        else $error("Lower priority position selected.");
    vec_p24_a: assert property (
        best_valid_o && best_pos_o == `POS_P24 |-> best_vec_o == `VEC_P24)
        else $error("Wrong vector for 24.");
    vec_p60_a: assert property (
        best_valid_o && best_pos_o == `POS_P60 |-> best_vec_o == `VEC_P60)
        else $error("Wrong vector for 60.");
    rsv_query_a: assert property (
        query_pos_i == `POS_RSV_49 |=> !query_valid_o)
        else $error("Reserved position reported a source.");
endmodule : irq_vector_map_and_edge_lines

// ---- verification/periph_src_model.sv ----
// Peripheral request sources that hold a level until software clears them.
`timescale 1ns/100ps
module periph_src_model (
    // Clock and reset.
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Raise and clear commands, one bit per source.
    input  wire logic [13:0] set_i,
    input  wire logic [13:0] clr_i,
    // Held request levels.
    output logic      [13:0] src_o
);
    // A source raises its flag on command and keeps it until it is cleared.
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            src_o <= 14'h0000;
        else
            src_o <= (src_o | set_i) & ~clr_i;
    end
endmodule : periph_src_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the interrupt position map and edge lines.
`timescale 1ns/100ps
module tb_top;
    logic                   core_clk_i = 1'b0;
    logic                   rst_n_i    = 1'b0;
    logic [13:0]            set_r      = 14'h0000;
    logic [13:0]            clr_r      = 14'h0000;
    logic [13:0]            src;
    logic                   hd         = 1'b0;
    logic                   remap      = 1'b0;
    irq_map_pkg::prio_arr_t prio       = 32'h0000_0000;
    irq_map_pkg::pos_t      qpos       = 6'h00;
    irq_map_pkg::line_vec_t pins       = 18'h00000;
    irq_map_pkg::line_vec_t rise       = 18'h3FFFD;
    irq_map_pkg::line_vec_t fall       = 18'h00006;
    irq_map_pkg::line_vec_t ien        = 18'h3FFF7;
    irq_map_pkg::line_vec_t een        = 18'h3FFF7;
    irq_map_pkg::line_vec_t ptype      = 18'h3FFEF;
    irq_map_pkg::line_vec_t swt        = 18'h00000;
    irq_map_pkg::line_vec_t pclr       = 18'h00000;
    logic [7:0]             slot_irq_o;
    logic                   best_valid_o;
    irq_map_pkg::pos_t      best_pos_o;
    irq_map_pkg::prio_t     best_prio_o;
    logic [31:0]            best_vec_o;
    logic                   query_valid_o;
    logic [31:0]            query_addr_o;
    irq_map_pkg::line_vec_t line_pend_o;
    irq_map_pkg::line_vec_t line_irq_o;
    irq_map_pkg::line_vec_t line_evt_o;
    int                     mismatches = 0;
    int                     cmp_count  = 0;
    int                     cycles     = 0;
    int                     slot_of[14] = '{0, 0, 1, 1, 2, 2, 2, 3, 4, 4, 5, 5, 6, 6};
    int                     qtab[7]     = '{24, 25, 26, 27, 41, 54, 59};
    logic                   hit;

    periph_src_model src_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .set_i(set_r),
        .clr_i(clr_r), .src_o(src));

    irq_vector_map_and_edge_lines dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .adv_timer_break_i(src[0]), .timer15_i(src[1]), .adv_timer_update_i(src[2]),
        .timer16_i(src[3]), .adv_timer_trigger_i(src[4]), .adv_timer_commut_i(src[5]),
        .timer17_i(src[6]), .adv_timer_capture_compare_i(src[7]), .alarm_a_i(src[8]),
        .alarm_b_i(src[9]), .basic_timer6_i(src[10]), .dac_underrun_i(src[11]),
        .dma_ctrl2_ch4_i(src[12]), .dma_ctrl2_ch5_i(src[13]), .high_density_i(hd),
        .misc_request_remap_bit_i(remap), .slot_prio_i(prio), .query_pos_i(qpos),
        .ext_lines_i(pins), .rise_en_i(rise), .fall_en_i(fall), .irq_en_i(ien),
        .evt_en_i(een), .pend_type_i(ptype), .sw_trig_i(swt), .pend_clr_i(pclr),
        .slot_irq_o(slot_irq_o), .best_valid_o(best_valid_o), .best_pos_o(best_pos_o),
        .best_prio_o(best_prio_o), .best_vec_o(best_vec_o), .query_valid_o(query_valid_o),
        .query_addr_o(query_addr_o), .line_pend_o(line_pend_o), .line_irq_o(line_irq_o),
        .line_evt_o(line_evt_o));

    // The clock toggles every half period of 5 ns.
    always #5 core_clk_i = ~core_clk_i;

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Pulses the peripheral raise and clear commands; slots other than position 41 are settled on return.
    task automatic srcs(input logic [13:0] s, input logic [13:0] c);
        @(posedge core_clk_i);
        set_r <= s;
        clr_r <= c;
        @(posedge core_clk_i);
        set_r <= 14'h0000;
        clr_r <= 14'h0000;
        @(posedge core_clk_i);
        #1;
    endtask : srcs

    // One-cycle software request or pending clear on line i.
    task automatic strobe(input logic sw, input int i);
        @(posedge core_clk_i);
        if (sw)
            swt <= 18'h00001 << i;
        else
            pclr <= 18'h00001 << i;
        @(posedge core_clk_i);
        swt <= 18'h00000;
        pclr <= 18'h00000;
        #1;
    endtask : strobe

    // Waits a bounded time for a pending bit (kind 0) or a slot request (kind 1).
    task automatic wait_hi(input logic kind, input int i, output logic h);
        h = 1'b0;
        for (int n = 0; n < 12 && !h; n++)
        begin
            @(posedge core_clk_i);
            #1;
            h = kind ? slot_irq_o[i] : line_pend_o[i];
        end
    endtask : wait_hi

    // Drives a pin level and checks whether the pending bit follows.
    task automatic edge_to(input int i, input logic lvl, input logic exp);
        @(posedge core_clk_i);
        pins[i] <= lvl;
        wait_hi(1'b0, i, hit);
        chk(hit, exp);
        if (hit)
            strobe(1'b0, i);
    endtask : edge_to

    task automatic query(input int p, input logic v);
        @(posedge core_clk_i);
        qpos <= 6'(p);
        @(posedge core_clk_i);
        #1;
        chk(query_valid_o, v);
        if (v)
            chk(query_addr_o, 32'h40 + 4 * p);
    endtask : query

    // Cuts a hung run short.
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            mismatches++;
            end_sim();
        end
    end

    // Main sequence of scenarios.
    initial
    begin
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        chk(slot_irq_o, 8'h00);
        chk(line_pend_o, 18'h00000);
        for (int k = 0; k < 14; k++)
            if (k != 8 && k != 9)
            begin
                srcs(14'h0001 << k, 14'h0000);
                chk(slot_irq_o, 8'h01 << slot_of[k]);
                srcs(14'h0000, 14'h0001 << k);
                chk(slot_irq_o, 8'h00);
            end
        srcs(14'h0030, 14'h0000);
        srcs(14'h0000, 14'h0010);
        chk(slot_irq_o, 8'h04);
        srcs(14'h0000, 14'h0020);
        chk(slot_irq_o, 8'h00);
        hd <= 1'b1;
        remap <= 1'b1;
        srcs(14'h2000, 14'h0000);
        chk(slot_irq_o, 8'h80);
        remap <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk(slot_irq_o, 8'h40);
        srcs(14'h0000, 14'h2000);
        prio <= 32'hF2FF_FFF5;
        srcs(14'h1001, 14'h0000);
        @(posedge core_clk_i);
        #1;
        chk({best_valid_o, best_pos_o, best_prio_o}, {1'b1, 6'h3B, 4'h2});
        chk(best_vec_o, 32'h0000_012C);
        prio <= 32'hF5FF_FFF5;
        @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        chk({best_pos_o, best_prio_o}, {6'h18, 4'h5});
        chk(best_vec_o, 32'h0000_00A0);
        @(posedge core_clk_i);
        prio <= 32'hF5FF_FF15;
        srcs(14'h0004, 14'h0000);
        @(posedge core_clk_i);
        #1;
        chk({best_pos_o, best_prio_o}, {6'h19, 4'h1});
        chk(best_vec_o, 32'h0000_00A4);
        srcs(14'h0000, 14'h1005);
        foreach (qtab[j])
            query(qtab[j], 1'b1);
        query(60, 1'b1);
        chk(query_addr_o, 32'h0000_0130);
        hd <= 1'b0;
        query(46, 1'b0);
        query(47, 1'b0);
        query(49, 1'b0);
        query(60, 1'b0);
        @(posedge core_clk_i);
        pins[0] <= 1'b1;
        wait_hi(1'b0, 0, hit);
        chk({hit, line_irq_o[0], line_evt_o[0]}, 3'h7);
        @(posedge core_clk_i);
        #1;
        chk({line_irq_o[0], line_evt_o[0]}, 2'h2);
        strobe(1'b0, 0);
        chk(line_pend_o[0], 1'b0);
        edge_to(1, 1'b1, 1'b0);
        edge_to(1, 1'b0, 1'b1);
        edge_to(2, 1'b1, 1'b1);
        edge_to(2, 1'b0, 1'b1);
        @(posedge core_clk_i);
        pins[3] <= 1'b1;
        repeat (8)
        begin
            @(posedge core_clk_i);
            #1;
            chk({line_irq_o[3], line_evt_o[3]}, 2'h0);
        end
        @(posedge core_clk_i);
        pins[4] <= 1'b1;
        wait_hi(1'b0, 4, hit);
        chk({hit, line_irq_o[4]}, 2'h3);
        @(posedge core_clk_i);
        #1;
        chk(line_irq_o[4], 1'b0);
        strobe(1'b1, 5);
        chk({line_pend_o[5], line_irq_o[5], line_evt_o[5]}, 3'h7);
        @(posedge core_clk_i);
        pins[6] <= 1'b1;
        @(posedge core_clk_i);
        @(posedge core_clk_i);
        pins[6] <= 1'b0;
        wait_hi(1'b0, 6, hit);
        chk(hit, 1'b1);
        srcs(14'h0100, 14'h0000);
        wait_hi(1'b1, 4, hit);
        chk(hit, 1'b1);
        srcs(14'h0000, 14'h0100);
        strobe(1'b0, 17);
        srcs(14'h0200, 14'h0000);
        wait_hi(1'b1, 4, hit);
        chk(hit, 1'b1);
        end_sim();
    end
endmodule : tb_top
